// >>> src/asp_ctrl.sv
module asp_ctrl
  import asp_pkg::*;
#(
  parameter int HPD_CYC = asp_pkg::HPD_LOW_CYC  // Hot-plug low limit in cycles
) (
  input  wire logic                     clk_sys_in,             // System clock
  input  wire logic                     sys_rst_in,             // Sync reset
  input  wire logic                     flip_scl_pin_in,        // Shared clock pin
  input  wire logic                     usb_path_ctrl_in,       // Shared data pin
  input  wire logic                     display_path_ctrl_in,   // Also hot_plug_in
  input  wire asp_pkg::asp_lvl_t        cfg_sel_strap_in,       // Mode strap
  input  wire asp_pkg::asp_lvl_t        display_eq_strap_lo_in, // Also addr_strap_bit1
  input  wire asp_pkg::asp_lvl_t        display_eq_strap_hi_in,
  input  wire asp_pkg::asp_lvl_t        usb_up_eq_strap_lo_in,  // Also addr_strap_bit0
  input  wire asp_pkg::asp_lvl_t        usb_up_eq_strap_hi_in,
  input  wire asp_pkg::asp_lvl_t        usb_dn_eq_strap_lo_in,  // Downstream eq straps
  input  wire asp_pkg::asp_lvl_t        usb_dn_eq_strap_hi_in,
  input  wire logic                     reg_display_en_in,      // From register file
  input  wire logic                     reg_usb_en_in,          // From register file
  input  wire logic                     reg_flip_in,            // From register file
  output logic                          strap_valid_out,        // Straps captured
  output logic                          serial_mode_out,        // Serial bus active
  output logic                          io_hi_volt_out,         // Serial I/O at 3.3 V
  output logic                          aeq_en_out,             // Adaptive eq on
  output logic [asp_pkg::ADDR_W-1:0]    dev_addr_out,           // Serial target address
  output logic [asp_pkg::EQ_SEL_W-1:0]  display_eq_sel_out,     // Display gain select
  output logic [asp_pkg::EQ_SEL_W-1:0]  usb_up_eq_sel_out,      // Upstream gain select
  output logic                          flip_out,               // Orientation
  output logic                          usb_path_en_out,        // USB switch on
  output logic                          display_en_out,         // Display lanes on
  output logic                          aux_sw_closed_out,      // Aux-to-sideband closed
  output logic                          aux_to_sbu1_out,        // Aux on first pins
  output logic                          aux_to_sbu2_out,        // Aux on second pins
  output logic                          serial_scl_out,         // Clock to serial slave
  output logic                          serial_sda_out          // Data to serial slave
);

  localparam int CNT_W = $clog2(HPD_CYC + 2);  // Counter holds limit plus one

  // Synchronised pins and straps
  asp_sync_if #(.W(SYNC_W)) pin_if (.clk(clk_sys_in));

  logic     clk_pin_s;   // Shared clock pin
  logic     data_pin_s;  // Shared data pin
  logic     dctl_pin_s;  // Display control or hot-plug pin
  asp_lvl_t cfg_s;       // Mode strap
  asp_lvl_t deq_lo_s;    // Display eq straps
  asp_lvl_t deq_hi_s;
  asp_lvl_t ueq_lo_s;    // Upstream eq straps
  asp_lvl_t ueq_hi_s;
  asp_lvl_t deq_dn_lo_s; // Downstream eq straps
  asp_lvl_t deq_dn_hi_s;

  assign pin_if.raw = {flip_scl_pin_in, usb_path_ctrl_in, display_path_ctrl_in,
                       cfg_sel_strap_in, display_eq_strap_lo_in, display_eq_strap_hi_in,
                       usb_up_eq_strap_lo_in, usb_up_eq_strap_hi_in,
                       usb_dn_eq_strap_lo_in, usb_dn_eq_strap_hi_in};

  asp_sync #(.W(SYNC_W)) u_sync (
    .sif    (pin_if.syncer),
    .rst_in (sys_rst_in)
  );

  assign {clk_pin_s, data_pin_s, dctl_pin_s, cfg_s, deq_lo_s, deq_hi_s,
          ueq_lo_s, ueq_hi_s, deq_dn_lo_s, deq_dn_hi_s} = pin_if.sync;

  // Strap decode of the current synchronised levels
  logic dec_serial;  // Serial bus selected
  logic dec_hiv;     // Serial bus at high I/O voltage
  logic dec_aeq;     // Adaptive eq selected

  always_comb begin
    dec_serial = 1'b0;
    dec_hiv    = 1'b0;
    dec_aeq    = 1'b0;
    case (cfg_s)
      LVL_ZERO: begin
        dec_serial = 1'b0;
        dec_aeq    = 1'b0;
      end
      LVL_ONE: begin
        dec_serial = 1'b1;
        dec_hiv    = 1'b1;
      end
      LVL_R: begin                                           // Test mode, bus at 3.3 V
        dec_serial = 1'b1;
        dec_hiv    = 1'b1;
      end
      default: begin                                         // Floating strap
        if (deq_dn_lo_s == LVL_ZERO && deq_dn_hi_s == LVL_ZERO) begin
          dec_serial = 1'b1;                                 // Bus at 1.8 V
        end else begin
          dec_aeq    = 1'b1;                                 // Pin mode with adaptive eq
        end
      end
    endcase
  end

  // Strap capture state
  asp_st_t                st_q, st_d;
  logic [1:0]             settle_q, settle_d;
  logic                   serial_q, serial_d;
  logic                   hiv_q, hiv_d;
  logic                   aeq_q, aeq_d;
  logic [ADDR_W-1:0]      addr_q, addr_d;
  logic [EQ_SEL_W-1:0]    deq_q, deq_d;
  logic [EQ_SEL_W-1:0]    ueq_q, ueq_d;

  // Wait for synchronisers, capture once, then hold
  always_comb begin
    st_d     = st_q;
    settle_d = settle_q;
    serial_d = serial_q;
    hiv_d    = hiv_q;
    aeq_d    = aeq_q;
    addr_d   = addr_q;
    deq_d    = deq_q;
    ueq_d    = ueq_q;
    case (st_q)
      ST_SETTLE: begin
        if (settle_q == SETTLE_LAST) begin
          st_d = ST_CAPTURE;
        end else begin
          settle_d = settle_q + 2'h1;
        end
      end
      ST_CAPTURE: begin
        serial_d = dec_serial;
        hiv_d    = dec_hiv;
        aeq_d    = dec_aeq;
        deq_d    = {deq_hi_s, deq_lo_s};
        ueq_d    = {ueq_hi_s, ueq_lo_s};
        addr_d   = dec_serial ? {deq_lo_s[1], ueq_lo_s[1]} : '0;
        st_d     = ST_RUN;
      end
      ST_RUN: begin                                          // Held until reset
        st_d = ST_RUN;
      end
      default: begin
        st_d = ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_q     <= ST_SETTLE;
      settle_q <= 2'h0;
      serial_q <= 1'b0;
      hiv_q    <= 1'b0;
      aeq_q    <= 1'b0;
      addr_q   <= '0;
      deq_q    <= '0;
      ueq_q    <= '0;
    end else begin
      st_q     <= st_d;
      settle_q <= settle_d;
      serial_q <= serial_d;
      hiv_q    <= hiv_d;
      aeq_q    <= aeq_d;
      addr_q   <= addr_d;
      deq_q    <= deq_d;
      ueq_q    <= ueq_d;
    end
  end

  wire run = (st_q == ST_RUN);  // Straps valid

  // Hot-plug low counter, register mode only
  logic [CNT_W-1:0] hpd_cnt_q, hpd_cnt_d;
  logic             hpd_timeout;  // Low longer than the limit

  assign hpd_timeout = (hpd_cnt_q > CNT_W'(HPD_CYC));

  always_comb begin
    hpd_cnt_d = '0;
    if (run && serial_q && !dctl_pin_s) begin
      hpd_cnt_d = hpd_timeout ? hpd_cnt_q : hpd_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      hpd_cnt_q <= '0;
    end else begin
      hpd_cnt_q <= hpd_cnt_d;
    end
  end

  // Pin routing and display control
  logic flip_q, flip_d;
  logic usb_q, usb_d;
  logic disp_q, disp_d;
  logic aux_q, aux_d;
  logic scl_q, scl_d;
  logic sda_q, sda_d;
  logic disp_req;  // Display requested by pin or register

  always_comb begin
    disp_req = 1'b0;
    flip_d   = 1'b0;
    usb_d    = 1'b0;
    scl_d    = 1'b1;                                         // Idle bus level
    sda_d    = 1'b1;
    if (run && !serial_q) begin
      flip_d   = clk_pin_s;
      usb_d    = data_pin_s;
      disp_req = dctl_pin_s;
    end else if (run) begin
      scl_d    = clk_pin_s;
      sda_d    = data_pin_s;
      flip_d   = reg_flip_in;
      usb_d    = reg_usb_en_in;
      disp_req = reg_display_en_in;
    end
    disp_d = disp_req && !(serial_q && hpd_timeout);
    aux_d  = disp_req;                                       // Stays closed on timeout
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      flip_q <= 1'b0;
      usb_q  <= 1'b0;
      disp_q <= 1'b0;
      aux_q  <= 1'b0;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      flip_q <= flip_d;
      usb_q  <= usb_d;
      disp_q <= disp_d;
      aux_q  <= aux_d;
      scl_q  <= scl_d;
      sda_q  <= sda_d;
    end
  end

  assign strap_valid_out    = run;
  assign serial_mode_out    = serial_q;
  assign io_hi_volt_out     = hiv_q;
  assign aeq_en_out         = aeq_q;
  assign dev_addr_out       = addr_q;
  assign display_eq_sel_out = deq_q;
  assign usb_up_eq_sel_out  = ueq_q;
  assign flip_out           = flip_q;
  assign usb_path_en_out    = usb_q;
  assign display_en_out     = disp_q;
  assign aux_sw_closed_out  = aux_q;
  assign aux_to_sbu1_out    = aux_q && !flip_q;
  assign aux_to_sbu2_out    = aux_q && flip_q;
  assign serial_scl_out     = scl_q;
  assign serial_sda_out     = sda_q;

  // Checks
  pin_flip_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (run && !serial_q) |=> (flip_out == $past(clk_pin_s)) && serial_scl_out)
    else $error("Flip not taken from clock pin in pin mode");
  ser_clock_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (run && serial_q) |=> (serial_scl_out == $past(clk_pin_s)) && (flip_out == $past(reg_flip_in)))
    else $error("Clock pin not routed to serial bus");
  usb_pin_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (run && !serial_q) |=> (usb_path_en_out == $past(data_pin_s)))
    else $error("USB switch not following data pin");
  disp_pin_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (run && !serial_q) |=> (display_en_out == $past(dctl_pin_s)))
    else $error("Display enable not following control pin");
  disp_reg_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (run && serial_q && !reg_display_en_in) |=> !display_en_out)
    else $error("Display enabled without register request");
  hpd_kill_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (hpd_timeout && reg_display_en_in) |=> !display_en_out && aux_sw_closed_out)
    else $error("Hot-plug timeout did not disable lanes");
  addr_map_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st_q == ST_CAPTURE && dec_serial) |=> dev_addr_out == {$past(deq_lo_s[1]), $past(ueq_lo_s[1])})
    else $error("Address not taken from straps");
  eq_sel_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st_q == ST_CAPTURE) |=> (display_eq_sel_out == {$past(deq_hi_s), $past(deq_lo_s)})
                           && (usb_up_eq_sel_out == {$past(ueq_hi_s), $past(ueq_lo_s)}))
    else $error("Eq select not captured");
  sbu_route_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (run && aux_d) |=> (aux_to_sbu2_out == flip_out) && (aux_to_sbu1_out != flip_out))
    else $error("Aux not routed by orientation");
  mode_zero_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st_q == ST_CAPTURE && cfg_s == LVL_ZERO) |=> !serial_mode_out && !aeq_en_out)
    else $error("Level zero did not select pin mode");
  strap_hold_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (run) |=> $stable(serial_q) && $stable(addr_q) && $stable(deq_q) && $stable(ueq_q))
    else $error("Strap result changed after capture");

endmodule : asp_ctrl

// >>> src/asp_pkg.sv
package asp_pkg;

  // Four-level strap as delivered by the pad comparator
  typedef logic [1:0] asp_lvl_t;

  localparam asp_lvl_t LVL_ZERO = 2'h0;  // Tied low
  localparam asp_lvl_t LVL_R    = 2'h1;  // Resistor to ground
  localparam asp_lvl_t LVL_F    = 2'h2;  // Floating
  localparam asp_lvl_t LVL_ONE  = 2'h3;  // Tied high

  // Strap capture sequence
  typedef enum logic [1:0] {ST_SETTLE, ST_CAPTURE, ST_RUN} asp_st_t;

  localparam int       CLK_PERIOD_NS = 40;         // System clock period
  localparam int       HPD_LOW_NS    = 2_000_000;  // Hot-plug low limit, 2 ms
  // Least time, rounded up to whole cycles
  localparam int       HPD_LOW_CYC   = (HPD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SETTLE_LAST = 2'h3;       // Last settle count, four cycles waited for synchronisers
  localparam int       SYNC_W        = 17;         // Pins plus seven straps
  localparam int       ADDR_W        = 2;          // Address strap bits
  localparam int       EQ_SEL_W      = 4;          // Two straps per gain select

endpackage : asp_pkg

// >>> src/asp_sync_if.sv
interface asp_sync_if #(parameter int W = 1) (input wire logic clk);
  logic [W-1:0] raw;   // Asynchronous pin levels
  logic [W-1:0] sync;  // Levels after two flip-flops

  modport syncer (input clk, input raw, output sync);
  modport user   (output raw, input sync);
endinterface : asp_sync_if

// >>> src/asp_sync.sv
module asp_sync #(
  parameter int W = 1
) (
  asp_sync_if.syncer    sif,     // Pins in, synchronised levels out
  input  wire logic     rst_in   // Synchronous reset, active high
);

  logic [W-1:0] meta_q;  // First stage, read only by the second
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;  // Second stage
  logic [W-1:0] sync_d;

  // Next values of both stages
  always_comb begin
    meta_d = sif.raw;
    sync_d = meta_q;
  end

  // Two-stage register
  always_ff @(posedge sif.clk) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sif.sync = sync_q;

endmodule : asp_sync

// >>> verif/asp_host_model.sv
module asp_host_model (
  input  wire logic                clk_sys_in,  // System clock
  output asp_pkg::asp_lvl_t        cfg_out,     // Mode strap level
  output asp_pkg::asp_lvl_t [5:0]  strap_out,   // Eq straps, 0 display lo .. 5 downstream hi
  output logic [2:0]               pin_out,     // Clock pin, data pin, display pin
  output logic [2:0]               reg_out      // Register display, usb, flip
);
  timeunit 1ns;
  timeprecision 1ps;
  import asp_pkg::*;

  // Controller holds every line low until told otherwise
  initial begin
    cfg_out   = LVL_ZERO;
    strap_out = '0;
    pin_out   = '0;
    reg_out   = '0;
  end

  // Straps are meant to move only while the block sits in reset
  task automatic set_straps(input asp_lvl_t cfg, input asp_lvl_t [5:0] eq);
    @(posedge clk_sys_in);
    cfg_out   <= cfg;
    strap_out <= eq;
  endtask : set_straps

  // Shared pins change just after an edge and then hold
  task automatic set_pins(input logic [2:0] p);
    @(posedge clk_sys_in);
    pin_out <= p;
  endtask : set_pins

  // Register-file controls, same clock as the block
  task automatic set_regs(input logic [2:0] r);
    @(posedge clk_sys_in);
    reg_out <= r;
  endtask : set_regs
endmodule : asp_host_model

// >>> verif/test_alt_mode_pin_strap_control.sv
module test_alt_mode_pin_strap_control;
  timeunit 1ns;
  timeprecision 1ps;
  import asp_pkg::*;

  localparam int HPD_T = 20;                    // Shortened hot-plug limit
  logic                 clk_sys_in = 1'b0;      // System clock
  logic                 sys_rst_in = 1'b1;      // Reset, held from time zero
  asp_lvl_t             cfg;                    // Mode strap from controller
  asp_lvl_t [5:0]       st;                     // Eq straps from controller
  logic [2:0]           pin, rg;                // Shared pins and register controls
  logic                 vld, ser, hv, aeq, flp, usb, dsp, aux, sb1, sb2, scl, sda;
  logic [1:0]           addr;                   // Serial target address
  logic [3:0]           deq, ueq;               // Gain selects
  int                   n_errors = 0;           // Mismatches seen
  int                   total_checks = 0;       // Comparisons made
  asp_lvl_t             cfg_tab [5] = '{LVL_ONE, LVL_R, LVL_F, LVL_F, LVL_ZERO};
  // Eq straps per boot: downstream hi, lo, upstream hi, lo, display hi, lo
  asp_lvl_t [5:0]       eq_tab  [5] = '{
    {LVL_ZERO, LVL_ZERO, LVL_ZERO, LVL_ONE,  LVL_F,    LVL_R},
    {LVL_ZERO, LVL_ZERO, LVL_R,    LVL_R,    LVL_ONE,  LVL_F},
    {LVL_ZERO, LVL_ZERO, LVL_ONE,  LVL_F,    LVL_ZERO, LVL_ONE},
    {LVL_R,    LVL_ZERO, LVL_F,    LVL_ZERO, LVL_R,    LVL_ZERO},
    {LVL_ZERO, LVL_R,    LVL_R,    LVL_ONE,  LVL_ONE,  LVL_F}
  };
  logic [1:0]           md_tab  [5] = '{2'h3, 2'h3, 2'h2, 2'h1, 2'h0};

  // 25 MHz clock
  always #20 clk_sys_in = ~clk_sys_in;

  asp_host_model HOST (.clk_sys_in(clk_sys_in), .cfg_out(cfg), .strap_out(st),
    .pin_out(pin), .reg_out(rg));

  asp_ctrl #(.HPD_CYC(HPD_T)) DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .flip_scl_pin_in(pin[2]), .usb_path_ctrl_in(pin[1]), .display_path_ctrl_in(pin[0]),
    .cfg_sel_strap_in(cfg), .display_eq_strap_lo_in(st[0]), .display_eq_strap_hi_in(st[1]),
    .usb_up_eq_strap_lo_in(st[2]), .usb_up_eq_strap_hi_in(st[3]),
    .usb_dn_eq_strap_lo_in(st[4]), .usb_dn_eq_strap_hi_in(st[5]),
    .reg_display_en_in(rg[2]), .reg_usb_en_in(rg[1]), .reg_flip_in(rg[0]),
    .strap_valid_out(vld), .serial_mode_out(ser), .io_hi_volt_out(hv), .aeq_en_out(aeq),
    .dev_addr_out(addr), .display_eq_sel_out(deq), .usb_up_eq_sel_out(ueq),
    .flip_out(flp), .usb_path_en_out(usb), .display_en_out(dsp), .aux_sw_closed_out(aux),
    .aux_to_sbu1_out(sb1), .aux_to_sbu2_out(sb2), .serial_scl_out(scl),
    .serial_sda_out(sda));

  // Verdict and end of run
  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // One comparison, reported at once on mismatch
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Let n edges pass, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc

  // Set straps, reset 16 cycles, check capture; md is {serial, hi volt or aeq}
  task automatic boot(input asp_lvl_t c, input asp_lvl_t [5:0] eq, input logic [1:0] md);
    HOST.set_straps(c, eq);
    HOST.set_pins(3'h0);
    HOST.set_regs(3'h0);
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    repeat (16) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    cyc(4);
    chk(vld, 8'h0, "strap valid early");
    cyc(1);
    chk({vld, ser, ser ? hv : aeq}, {1'b1, md}, "mode decode");
    chk(addr, md[1] ? {eq[0][1], eq[2][1]} : 2'h0, "address");
    chk({deq, ueq}, {eq[1], eq[0], eq[3], eq[2]}, "eq selects");
  endtask : boot

  // Main sequence
  initial begin
    for (int i = 0; i < 5; i++) begin
      boot(cfg_tab[i], eq_tab[i], md_tab[i]);
    end
    // Pin mode: pins steer orientation, USB and display
    chk({scl, sda, dsp}, 8'h6, "pin mode idle");
    HOST.set_pins(3'h7);
    cyc(2);
    chk(flp, 8'h0, "flip too early");
    cyc(1);
    chk({flp, usb, dsp, aux, sb1, sb2}, 8'h3D, "pins high");
    HOST.set_pins(3'h1);
    cyc(3);
    chk({flp, usb, dsp, sb1, scl, sda}, 8'h0F, "flip low");
    HOST.set_pins(3'h0);
    cyc(3);
    chk(dsp, 8'h0, "display pin low");
    HOST.set_straps(LVL_ONE, '1);
    cyc(8);
    chk({ser, addr}, 8'h0, "straps after capture");
    // Register mode: display from registers, pins are serial lines
    boot(LVL_ONE, eq_tab[0], 2'h3);
    HOST.set_pins(3'h1);
    cyc(3);
    chk(dsp, 8'h0, "display pin ignored");
    HOST.set_regs(3'h7);
    cyc(1);
    chk({flp, usb, dsp, sb2}, 8'hF, "register controls");
    HOST.set_regs(3'h4);
    HOST.set_pins(3'h7);
    cyc(3);
    chk({flp, usb, scl, sda}, 8'h3, "serial lines high");
    HOST.set_pins(3'h1);
    cyc(3);
    chk({scl, sda}, 8'h0, "serial lines low");
    // Hot-plug held low past the limit
    HOST.set_pins(3'h0);
    cyc(HPD_T + 3);
    chk(dsp, 8'h1, "hot-plug low at limit");
    cyc(1);
    chk({dsp, aux}, 8'h1, "hot-plug timeout");
    HOST.set_pins(3'h1);
    cyc(5);
    chk(dsp, 8'h1, "hot-plug back high");
    finish_test();
  end

  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #100us;
    n_errors++;
    finish_test();
  end
endmodule : test_alt_mode_pin_strap_control
